// *** logic/cycle_progress_defs.vh ***
// constants for the memory bus cycle progress tracker
// assumes inclusion by bare name from design files under logic/
`ifndef CYCLE_PROGRESS_DEFS_VH
`define CYCLE_PROGRESS_DEFS_VH
// cycle type codes, one bit each
`define CT_WIDTH      4
`define CT_NONE       4'h0
`define CT_LINE_FILL  4'h1
`define CT_ALLOC      4'h2
`define CT_WT_PALLOC  4'h4
`define CT_WT_UPGRADE 4'h8
// bit positions inside the cycle type code
`define CT_BIT_LFIL   0
`define CT_BIT_ALLOC  1
`define CT_BIT_WTPA   2
`define CT_BIT_WTPU   3
// spacing figures for first burst ready, in clocks
`define SNOOP_GAP_BASE 8'h01
`define LINE_MULT      8'h04
`define LINE_SHIFT     2
`define RATIO_WIDTH    4
`define GAP_WIDTH      8
`define ONE_GAP        8'h01
`define ZERO_GAP       8'h00
`define RATIO_RESET    4'h1
// state codes, one-hot
`define ST_IDLE   4'h1
`define ST_ACTIVE 4'h2
`define ST_SNPWB  4'h4
`define ST_SNOOP  4'h8
`endif

// *** logic/gap_counter.v ***
// down counter timing the least spacing before a first burst ready
// assumes a load pulse restarts it and expired is high once the count ran out
`timescale 1ns/1ps
`default_nettype none
`include "cycle_progress_defs.vh"
module gap_counter #(
  parameter W = 8
) (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire         load,
  input  wire [W-1:0] load_value,
  output reg          expired
);
  reg [W-1:0] count;  // clocks still to wait

  // load restarts, otherwise count down to zero
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count   <= {W{1'b0}};
      expired <= 1'b1;
    end else if (load) begin
      count   <= load_value;
      expired <= 1'b0;
    end else if (count != {W{1'b0}}) begin
      count   <= count - {{(W-1){1'b0}}, 1'b1};
      expired <= 1'b0;
    end else begin
      expired <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** logic/memory_bus_cycle_progress.v ***
// tracker of the memory bus cycle progress handshake of a cache controller
// assumes all inputs synchronous to ref_clk, strobes active high, one clock
`timescale 1ns/1ps
`default_nettype none
`include "cycle_progress_defs.vh"
module memory_bus_cycle_progress #(
  parameter LRW = `RATIO_WIDTH,
  parameter GW  = `GAP_WIDTH
) (
  input  wire           ref_clk,
  input  wire           rst,
  // requests from the controller core
  input  wire           start_request,      // begin a cycle with address strobe
  input  wire           snoop_wb_request,   // begin a snoop writeback
  input  wire           memory_or_io_select,
  input  wire           write_or_read_select,
  input  wire           cacheable_request,  // active when set
  input  wire           ready_source,
  input  wire           potential_allocate, // active when set
  input  wire           locked_cycle,       // active when set
  input  wire           page_cache_disable,
  input  wire           page_writethrough,
  input  wire [LRW-1:0] line_ratio,
  // responses from the bus controller
  input  wire           bus_guarantee,
  input  wire           cacheability_window_end,
  input  wire           snoop_window_end,
  input  wire           cycle_ready,
  input  wire           next_address_request,
  input  wire           memory_cacheable_response,
  input  wire           memory_read_only_response,
  input  wire           writeback_select_response,
  input  wire           direct_to_modified,
  input  wire           memory_bus_data_ready,
  input  wire           memory_end_of_cycle,
  input  wire           cpu_burst_ready,
  input  wire           snoop_cycle_indication,
  // outputs to the bus
  output reg            cycle_address_strobe,
  output reg            snoop_address_strobe,
  output reg            data_transfer_start,
  // state seen by the core
  output wire           busy,
  output reg            guarantee_seen,
  output reg            cacheability_end_seen,
  output reg            snoop_end_seen,
  output reg            next_address_seen,
  output reg            snoops_enabled,
  output reg            cacheable_latched,
  output reg            read_only_latched,
  output reg            writeback_latched,
  output reg            modified_latched,
  output reg  [`CT_WIDTH-1:0] cycle_type,
  output reg            cycle_done,
  output reg            order_error,        // partner broke an ordering
  output wire           burst_ready_allowed
);
  localparam [3:0] IDLE   = `ST_IDLE;
  localparam [3:0] ACTIVE = `ST_ACTIVE;
  localparam [3:0] SNPWB  = `ST_SNPWB;
  localparam [3:0] SNOOP  = `ST_SNOOP;

  reg [3:0]     state;          // current cycle phase
  reg [3:0]     next_state;     // phase for the next clock
  reg [LRW-1:0] ratio;          // line ratio caught after reset
  reg           ratio_taken;    // ratio already captured
  reg           first_cpu_burst_ready_done; // first burst ready of cycle seen
  reg           eoc_seen;       // end of cycle seen in this cycle
  reg           eoc_block;      // one clock after ready, no end of cycle
  reg           data_seen;      // some data ready seen this cycle
  reg           snoop_load;     // reload snoop gap counter
  reg           first_cpu_burst_ready_load;     // reload previous-first gap counter
  wire          snoop_gap_ok;   // snoop spacing elapsed
  wire          first_cpu_burst_ready_gap_ok;   // first-to-first spacing elapsed
  wire          window_open;    // progress inputs are recognised
  wire          wb_cycle;       // snoop writeback in progress
  wire [GW-1:0] line_gap;       // four times line ratio
  wire [GW-1:0] snoop_gap;      // one plus four times line ratio

  // decode cycle type from the request attributes
  function [`CT_WIDTH-1:0] classify;
    input mio, wr, cache, rdy, palloc, lock, pcd, pwt;
    begin
      classify = `CT_NONE;
      classify[`CT_BIT_LFIL]  = mio & ~wr & cache & rdy;
      classify[`CT_BIT_ALLOC] = mio & ~wr & cache & ~rdy;
      classify[`CT_BIT_WTPA]  = palloc;
      classify[`CT_BIT_WTPU]  = mio & wr & ~palloc & ~lock & ~pcd & ~pwt;
    end
  endfunction

  // spacing in clocks scaled from the line ratio
  function [GW-1:0] scale_ratio;
    input [LRW-1:0] r;
    input [GW-1:0]  base;
    begin
      scale_ratio = base + ({{(GW-LRW){1'b0}}, r} << `LINE_SHIFT);
    end
  endfunction

  assign line_gap  = scale_ratio(ratio, `ZERO_GAP);
  assign snoop_gap = scale_ratio(ratio, `SNOOP_GAP_BASE);
  assign busy      = (state != IDLE);
  assign wb_cycle  = (state == SNPWB);
  // sampling only inside a cycle, which opens after previous ready
  assign window_open = (state == ACTIVE);
  assign burst_ready_allowed = snoop_gap_ok & first_cpu_burst_ready_gap_ok;

  // capture line ratio once after release of reset, static afterwards
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ratio       <= `RATIO_RESET;
      ratio_taken <= 1'b0;
    end else if (!ratio_taken) begin
      ratio       <= line_ratio;
      ratio_taken <= 1'b1;
    end
  end

  // next phase; a new request waits for cycle ready of the last
  always @* begin
    next_state = state;
    case (state)
      IDLE: begin
        if (snoop_wb_request)
          next_state = SNOOP;                                        // strobe first
        else if (start_request)
          next_state = ACTIVE;
      end
      SNOOP:  next_state = SNPWB;
      ACTIVE: if (cycle_ready) next_state = IDLE;
      SNPWB:  if (cycle_ready) next_state = IDLE;
      default: next_state = IDLE;
    endcase
  end

  // strobes and phase; snoop writeback wins so strobes never coincide
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state                <= IDLE;
      cycle_address_strobe <= 1'b0;
      snoop_address_strobe <= 1'b0;
      data_transfer_start  <= 1'b0;
      cycle_type           <= `CT_NONE;
      cycle_done           <= 1'b0;
    end else begin
      state                <= next_state;
      cycle_address_strobe <= (state == IDLE) & ~snoop_wb_request & start_request;
      snoop_address_strobe <= (state == IDLE) & snoop_wb_request;
      // transfer start with address strobe, or a clock after snoop strobe
      data_transfer_start  <= ((state == IDLE) & ~snoop_wb_request & start_request)
                              | (state == SNOOP);
      cycle_done           <= (state == ACTIVE | state == SNPWB) & cycle_ready;
      if ((state == IDLE) & ~snoop_wb_request & start_request)
        cycle_type <= classify(memory_or_io_select, write_or_read_select,
                               cacheable_request, ready_source,
                               potential_allocate, locked_cycle,
                               page_cache_disable, page_writethrough);
    end
  end

  // progress inputs: latched in window, seen flags held until cycle ready, attribute latches kept
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      guarantee_seen        <= 1'b0;
      cacheability_end_seen <= 1'b0;
      snoop_end_seen        <= 1'b0;
      next_address_seen     <= 1'b0;
      cacheable_latched     <= 1'b0;
      read_only_latched     <= 1'b0;
      writeback_latched     <= 1'b0;
      modified_latched      <= 1'b0;
    end else if (cycle_ready & (window_open | wb_cycle)) begin
      guarantee_seen        <= 1'b0;
      cacheability_end_seen <= 1'b0;
      snoop_end_seen        <= 1'b0;
      next_address_seen     <= 1'b0;
    end else if (window_open) begin
      // guarantee only for strobe-started cycles
      if (bus_guarantee)
        guarantee_seen <= 1'b1;
      // cacheability end counts after guarantee, attributes sampled there
      if (cacheability_window_end & (guarantee_seen | bus_guarantee)
          & ~cacheability_end_seen
          & (cycle_type[`CT_BIT_LFIL] | cycle_type[`CT_BIT_ALLOC]
             | cycle_type[`CT_BIT_WTPA])) begin
        cacheability_end_seen <= 1'b1;
        cacheable_latched     <= memory_cacheable_response;
        read_only_latched     <= memory_read_only_response;
      end
      // snoop end after guarantee is taken for every cycle type, as it reopens snooping
      if (snoop_window_end & (guarantee_seen | bus_guarantee) & ~snoop_end_seen) begin
        snoop_end_seen <= 1'b1;
        if (cycle_type != `CT_NONE) begin
          writeback_latched <= writeback_select_response;
          modified_latched  <= direct_to_modified;
        end
      end
      // next address recognised between guarantee and ready
      if (next_address_request & (guarantee_seen | bus_guarantee))
        next_address_seen <= 1'b1;
    end
    // outside the window nothing is taken; writeback ignores next address
  end

  // snoops off from strobe until snoop end or cycle ready
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      snoops_enabled <= 1'b1;
    else if (state == ACTIVE & cycle_ready)
      snoops_enabled <= 1'b1;
    else if (window_open & snoop_window_end & (guarantee_seen | bus_guarantee))
      snoops_enabled <= 1'b1;
    else if (cycle_address_strobe)
      snoops_enabled <= 1'b0;
  end

  // checks on the partner's ordering of data, end-of-cycle and window-end signals
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      eoc_seen        <= 1'b0;
      eoc_block       <= 1'b0;
      data_seen       <= 1'b0;
      first_cpu_burst_ready_done <= 1'b0;
      order_error     <= 1'b0;
    end else begin
      eoc_block <= cycle_ready;
      if (cycle_address_strobe) begin
        eoc_seen        <= 1'b0;
        data_seen       <= 1'b0;
        first_cpu_burst_ready_done <= 1'b0;
      end else begin
        if (memory_end_of_cycle)
          eoc_seen <= 1'b1;
        if (memory_bus_data_ready)
          data_seen <= 1'b1;
        if (cpu_burst_ready)
          first_cpu_burst_ready_done <= 1'b1;
      end
      // sticky until reset; the seven broken orders below are flagged
      if ((memory_bus_data_ready & (cycle_address_strobe | state == IDLE))
          | (memory_bus_data_ready & eoc_seen & ~memory_end_of_cycle)
          | (cycle_ready & state == ACTIVE & ~eoc_seen & ~memory_end_of_cycle)
          | (memory_end_of_cycle & (eoc_block | cpu_burst_ready))
          | (cpu_burst_ready & ~first_cpu_burst_ready_done & ~burst_ready_allowed)
          | (window_open & cacheability_window_end & ~guarantee_seen
             & ~bus_guarantee)
          | (window_open & snoop_window_end & ~cacheability_end_seen
             & ~cacheability_window_end & cycle_type[`CT_BIT_LFIL]))
        order_error <= 1'b1;
    end
  end

  // reload triggers for the two spacing counters
  always @* begin
    snoop_load = snoop_cycle_indication & ~guarantee_seen;
    first_cpu_burst_ready_load = cpu_burst_ready & ~first_cpu_burst_ready_done & busy;
  end

  gap_counter #(.W(GW)) snoop_spacing (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .load       (snoop_load),
    .load_value (snoop_gap),
    .expired    (snoop_gap_ok)
  );

  gap_counter #(.W(GW)) first_spacing (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .load       (first_cpu_burst_ready_load),
    .load_value (line_gap),
    .expired    (first_cpu_burst_ready_gap_ok)
  );
endmodule
`default_nettype wire

// *** bench/cycle_progress_props.sv ***
// checker for the memory bus cycle progress tracker
// assumes it is bound onto the tracker top, all on ref_clk
`timescale 1ns/1ps
`default_nettype none
module cycle_progress_props #(
  parameter LRW = 4
) (
  input wire logic           ref_clk,
  input wire logic           rst,
  input wire logic [LRW-1:0] line_ratio,
  input wire logic           bus_guarantee,
  input wire logic           snoop_window_end,
  input wire logic           cycle_ready,
  input wire logic           next_address_request,
  input wire logic           snoop_cycle_indication,
  input wire logic           cycle_address_strobe,
  input wire logic           snoop_address_strobe,
  input wire logic           data_transfer_start,
  input wire logic           busy,
  input wire logic           guarantee_seen,
  input wire logic           next_address_seen,
  input wire logic           snoops_enabled,
  input wire logic           cycle_done,
  input wire logic           burst_ready_allowed
);
  reg       snoop_phase;  // inside a snoop writeback
  reg [7:0] since_snoop;  // clocks since a counted snoop indication
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // saturating spacing counter; only indications before the guarantee count
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      snoop_phase <= 1'b0;
      since_snoop <= 8'hff;
    end else begin
      snoop_phase <= snoop_address_strobe | (snoop_phase & busy);
      if (snoop_cycle_indication && busy && !guarantee_seen && !bus_guarantee)
        since_snoop <= 8'h00;
      else if (since_snoop != 8'hff)
        since_snoop <= since_snoop + 8'h01;
    end
  end
  a_strobes_apart: assert property (!(cycle_address_strobe && snoop_address_strobe))
    else $error("both strobes in one clock");
  a_snoop_xfer_gap: assert property (
      snoop_address_strobe |-> !data_transfer_start ##1 data_transfer_start)
    else $error("transfer start not one clock after snoop strobe");
  a_take_when_idle: assert property (
      cycle_address_strobe |-> !$past(busy) && data_transfer_start)
    else $error("cycle strobe while a cycle was open");
  a_ready_clears: assert property (
      busy && cycle_ready |=> cycle_done && !busy && !guarantee_seen && !next_address_seen)
    else $error("latched progress not cleared by ready");
  a_idle_ignore: assert property (
      !busy && (bus_guarantee || next_address_request) |=> !guarantee_seen && !next_address_seen)
    else $error("progress input taken while idle");
  a_snpwb_only_ready: assert property (
      snoop_phase |-> !guarantee_seen && !next_address_seen)
    else $error("snoop writeback took more than ready");
  a_snoops_stay_off: assert property (
      busy && !snoops_enabled && !snoop_window_end && !cycle_ready |=> !snoops_enabled)
    else $error("snoops enabled without snoop end or ready");
  a_snoop_spacing: assert property (
      burst_ready_allowed |-> since_snoop > {line_ratio, 2'b00})
    else $error("burst ready allowed too soon after snoop");
endmodule
bind memory_bus_cycle_progress cycle_progress_props #(.LRW(LRW)) props (
  .ref_clk(ref_clk), .rst(rst), .line_ratio(line_ratio), .bus_guarantee(bus_guarantee),
  .snoop_window_end(snoop_window_end), .cycle_ready(cycle_ready),
  .next_address_request(next_address_request), .snoop_cycle_indication(snoop_cycle_indication),
  .cycle_address_strobe(cycle_address_strobe), .snoop_address_strobe(snoop_address_strobe),
  .data_transfer_start(data_transfer_start), .busy(busy), .guarantee_seen(guarantee_seen),
  .next_address_seen(next_address_seen), .snoops_enabled(snoops_enabled),
  .cycle_done(cycle_done), .burst_ready_allowed(burst_ready_allowed));
`default_nettype wire

// *** bench/memory_bus_controller_model.sv ***
// behavioural memory bus controller answering the tracker's strobes
// assumes one-clock strobes on ref_clk; bra is the tracker's burst gate
`timescale 1ns/1ps
`default_nettype none
module memory_bus_controller_model (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic cas,    // cycle address strobe
  input  wire logic sas,    // snoop address strobe
  input  wire logic bra,    // first burst ready allowed
  input  wire logic slow,   // late guarantee
  input  wire logic swen,   // send snoop window end
  input  wire logic stray,  // drive progress out of window on purpose
  output wire logic bg,     // bus guarantee
  output wire logic kw,     // cacheability window end
  output wire logic sw,     // snoop window end
  output wire logic cr,     // cycle ready
  output wire logic na,     // next address request
  output wire logic mc,     // memory cacheable response
  output wire logic mr,     // memory read only response
  output wire logic wb,     // writeback select response
  output wire logic dm,     // direct to modified
  output wire logic mbr,    // memory bus data ready
  output wire logic eoc,    // memory end of cycle
  output wire logic cbr,    // cpu burst ready
  output wire logic sci     // snoop cycle indication
);
  reg        run;  // a cycle in flight
  reg        snp;  // cycle opened by the snoop strobe
  reg        tog;  // filler for attribute lines outside their sample clock
  reg  [4:0] cnt;  // clocks since the strobe
  wire [4:0] g    = slow ? 5'h06 : 5'h02;                   // guarantee slot
  wire       act  = run & !snp;
  wire       hold = act & (cnt == g + 5'h03) & !bra;        // wait out spacing
  // sequencer; every input held exactly one clock
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run <= 1'b0;
      snp <= 1'b0;
      tog <= 1'b0;
      cnt <= 5'h00;
    end else begin
      tog <= !tog;
      if (cas | sas) begin
        run <= 1'b1;
        snp <= sas;
        cnt <= 5'h00;
      end else if (run && cnt == g + 5'h04)
        run <= 1'b0;
      else if (run && !hold)
        cnt <= cnt + 5'h01;
    end
  end
  assign bg  = stray | act & (cnt == g);
  assign sci = act & (cnt == 5'h01);
  assign kw  = act & (cnt == g + 5'h01);
  assign sw  = stray | act & swen & (cnt == g + 5'h02);
  assign na  = stray | act & (cnt == g + 5'h02);
  assign mbr = act & (cnt == g + 5'h03) & bra;
  assign cbr = mbr;
  assign eoc = run & (cnt == g + 5'h04);
  assign cr  = eoc;
  assign mc  = kw ? 1'b1 : tog;
  assign mr  = kw ? 1'b0 : tog;
  assign wb  = sw ? 1'b1 : tog;
  assign dm  = sw ? 1'b0 : tog;
endmodule
`default_nettype wire

// *** bench/memory_bus_cycle_progress_tb.sv ***
// self-checking bench for the memory bus cycle progress tracker
// assumes the tracker, its checker and the controller model compile first
`timescale 1ns/1ps
`default_nettype none
module memory_bus_cycle_progress_tb;
  reg        ref_clk = 1'b0;
  reg        rst = 1'b1;
  reg        start_request = 1'b0;
  reg        snoop_wb_request = 1'b0;
  reg        slow = 1'b0;
  reg        swen = 1'b1;
  reg        stray = 1'b0;
  reg  [7:0] attr = 8'h00;   // mio, wr, cache, rdy, potential_allocate, lock, pcd, pwt
  reg [11:0] rows [0:6];     // attributes beside expected cycle type
  wire       bg, kw, sw, cr, na, mc, mr, wb, dm, mbr, eoc, cbr, sci;
  wire       cas, sas, dts, busy, gs, ns, se, done, oe, bra;
  wire       ces, ses, cl, rl, wbl, dml;
  wire [3:0] ctype;
  int        bad_count = 0;
  int        compares = 0;
  int        strobes;
  always #2 ref_clk = !ref_clk;
  memory_bus_cycle_progress dut (
    .ref_clk(ref_clk), .rst(rst), .start_request(start_request),
    .snoop_wb_request(snoop_wb_request), .memory_or_io_select(attr[7]),
    .write_or_read_select(attr[6]), .cacheable_request(attr[5]), .ready_source(attr[4]),
    .potential_allocate(attr[3]), .locked_cycle(attr[2]), .page_cache_disable(attr[1]),
    .page_writethrough(attr[0]), .line_ratio(4'h1), .bus_guarantee(bg),
    .cacheability_window_end(kw), .snoop_window_end(sw), .cycle_ready(cr),
    .next_address_request(na), .memory_cacheable_response(mc),
    .memory_read_only_response(mr), .writeback_select_response(wb),
    .direct_to_modified(dm), .memory_bus_data_ready(mbr), .memory_end_of_cycle(eoc),
    .cpu_burst_ready(cbr), .snoop_cycle_indication(sci), .cycle_address_strobe(cas),
    .snoop_address_strobe(sas), .data_transfer_start(dts), .busy(busy),
    .guarantee_seen(gs), .cacheability_end_seen(ces), .snoop_end_seen(ses),
    .next_address_seen(ns), .snoops_enabled(se), .cacheable_latched(cl),
    .read_only_latched(rl), .writeback_latched(wbl), .modified_latched(dml),
    .cycle_type(ctype), .cycle_done(done), .order_error(oe), .burst_ready_allowed(bra));
  memory_bus_controller_model partner (
    .ref_clk(ref_clk), .rst(rst), .cas(cas), .sas(sas), .bra(bra), .slow(slow),
    .swen(swen), .stray(stray), .bg(bg), .kw(kw), .sw(sw), .cr(cr), .na(na), .mc(mc),
    .mr(mr), .wb(wb), .dm(dm), .mbr(mbr), .eoc(eoc), .cbr(cbr), .sci(sci));
  // compare and count
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait for the ready clock of the open cycle
  task automatic wait_ready();
    for (int k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      #1;
      if (cr === 1'b1) return;
    end
    bad_count++;
    $display("ERROR cycle_ready expected 1 seen 0");
  endtask
  // one strobe cycle from request to done
  task automatic run_cycle(input logic [11:0] row, input logic s);
    @(posedge ref_clk);
    #1;
    attr = row[11:4];
    slow = s;
    start_request = 1'b1;
    @(posedge ref_clk);
    #1;
    start_request = 1'b0;
    check("strobe_xfer", 4'h3, {2'b00, cas, dts});
    check("cycle_type", row[3:0], ctype);
    repeat (3) @(posedge ref_clk);
    #1;
    check("burst_gate", 4'h0, {3'b000, bra});
    wait_ready();
    check("held_state", {3'b011, swen}, {1'b0, ns, gs, se});
    check("window_ends", {|row[2:0], swen, 2'b10}, {ces, ses, wbl, dml});
    check("attr_latches", 4'h2, {2'b00, cl, rl});
    @(posedge ref_clk);
    #1;
    check("after_ready", 4'ha, {done, busy, se, gs});
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rows = '{12'hb01, 12'ha02, 12'hc84, 12'hc08, 12'hc40, 12'h300, 12'hc20};
    repeat (8) @(posedge ref_clk);
    #1;
    check("reset_quiet", 4'h0, {busy, cas, sas, dts});
    check("reset_levels", 4'hc, {se, bra, gs, done});
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    $display("test reset done");
    for (int i = 0; i < 7; i++) run_cycle(rows[i], i[0]);
    check("order_error", 4'h0, {3'b000, oe});
    $display("test cycle types done");
    swen = 1'b0;
    run_cycle(rows[0], 1'b1);
    swen = 1'b1;
    $display("test snoops held off done");
    start_request = 1'b1;   // held six clocks, released before ready
    strobes = 0;
    repeat (6) begin
      @(posedge ref_clk);
      #1;
      strobes += cas;
    end
    start_request = 1'b0;
    wait_ready();
    @(posedge ref_clk);
    #1;
    check("strobe_count", 4'h1, strobes[3:0]);
    stray = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check("idle_latches", 4'h0, {2'b00, gs, ns});
    stray = 1'b0;
    $display("test refusals done");
    snoop_wb_request = 1'b1;
    start_request = 1'b1;   // both at once, the snoop writeback must win
    @(posedge ref_clk);
    #1;
    snoop_wb_request = 1'b0;
    start_request = 1'b0;
    check("snoop_strobe", 4'h2, {1'b0, cas, sas, dts});
    stray = 1'b1;
    @(posedge ref_clk);
    #1;
    check("snoop_xfer", 4'h1, {3'b000, dts});
    wait_ready();
    check("snoop_latches", 4'h0, {2'b00, gs, ns});
    stray = 1'b0;
    @(posedge ref_clk);
    #1;
    check("snoop_done", 4'h2, {2'b00, done, busy});
    $display("test snoop writeback done");
    check("order_clean", 4'h0, {3'b000, oe});
    stray = 1'b1;   // snoop end ahead of cacheability end on a line fill
    attr = rows[0][11:4];
    start_request = 1'b1;
    @(posedge ref_clk);
    #1;
    start_request = 1'b0;
    wait_ready();
    @(posedge ref_clk);
    #1;
    stray = 1'b0;
    check("order_flag", 4'h1, {3'b000, oe});
    $display("test order monitor done");
    wrap_up();
  end
  // hang guard, far beyond the few hundred clocks the tests take
  initial begin
    #20000;
    bad_count++;
    $display("ERROR watchdog expected finish seen hang");
    wrap_up();
  end
endmodule
`default_nettype wire
